// ### hdl/mpt_consts.svh
// Purpose: constants for the match based pulse timer
// Assumes: one 100 MHz clock, synchronous active low reset
// Notes: rule summary below
// How it works
// R1: 32-bit counter steps once per terminal count of a 32-bit prescaler.
// R2: timer mode counts clock; counter mode counts selected capture input edges.
// R3: seven match registers give up to six single or three double edge outputs.
// R4: each match may continue, stop or reset, and may raise an interrupt.
// R5: match zero sets the period by resetting the counter, shared by all outputs.
// R6: single edge outputs rise at cycle start unless constant low; a match drops them.
// R7: one extra match per single edge output, two per double edge output.
// R8: double edge output rises at one match, falls at another, either order.
// R9: software releases new match values; in pulse mode they apply only at cycle start, in timer mode at once.
// R10: with pulse mode off, pulse outputs stay low and the block is a plain timer.
// R11: two units run in step; master enable drives slave enable.
// R12: four external match outputs go low, high, toggle or hold on match.
// R13: capture input edge latches the count and may raise an interrupt.
// R14: any count value is accepted for period and width.
// R15: match is counter equal to register; reset returns to zero next step.
`ifndef MPT_CONSTS_SVH
`define MPT_CONSTS_SVH
`define MPT_NUM_MATCH 7
`define MPT_NUM_CAP 4
`define MPT_NUM_EXT 4
`define MPT_NUM_PWM 6
`define MPT_CNT_RESET 32'h0000_0000
`define MPT_ACT_RESET_BIT 1
`define MPT_ACT_STOP_BIT 2
`define MPT_ACT_IRQ_BIT 0
`endif

// ### hdl/mpt_pkg.sv
// Purpose: types for the match based pulse timer
// Assumes: nothing
// Notes: external match action encoding
package mpt_pkg;
	typedef enum logic [1:0]
	{
		MPT_EXT_HOLD = 2'h0,
		MPT_EXT_LOW = 2'h1,
		MPT_EXT_HIGH = 2'h2,
		MPT_EXT_TOGGLE = 2'h3
	} mpt_ext_type;
endpackage

// ### hdl/mpt_edge_sync.sv
// Purpose: two flop synchroniser with edge detect for one pin
// Assumes: pin is asynchronous to clk
// Notes: first flop read only by second
`timescale 1ns/1ps
module mpt_edge_sync
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// pin and selection
	input wire logic pin,
	input wire logic [1:0] edge_sel,
	// result
	output logic level,
	output logic hit
);
	logic s1_q;
	logic s2_q;
	logic s3_q;
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			s1_q <= 1'h0;
			s2_q <= 1'h0;
			s3_q <= 1'h0;
		end
		else
		begin
			s1_q <= pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end
	assign level = s2_q;
	// bit0 rising, bit1 falling
	assign hit = (edge_sel[0] & s2_q & ~s3_q) | (edge_sel[1] & ~s2_q & s3_q);
endmodule

// ### hdl/mpt_timer.sv
// Purpose: seven match pulse timer with capture and external match outputs
// Assumes: software keeps match values stable until release is seen
// Notes: match zero is the period register in pulse mode
`timescale 1ns/1ps
`include "mpt_consts.svh"
module mpt_timer
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// control
	input wire logic enable,
	input wire logic counter_mode,
	input wire logic [1:0] count_cap_sel,
	input wire logic [1:0] count_edge,
	input wire logic pwm_enable,
	input wire logic [5:0] double_edge,
	input wire logic [5:0] const_low,
	input wire logic slave_mode,
	input wire logic sync_enable_in,
	input wire logic [31:0] prescale,
	// match values and per match actions
	input wire logic [`MPT_NUM_MATCH*32-1:0] match_val,
	input wire logic [`MPT_NUM_MATCH*3-1:0] match_act,
	input wire logic [`MPT_NUM_MATCH-1:0] match_release,
	input wire logic [`MPT_NUM_EXT*2-1:0] ext_act,
	// capture
	input wire logic [`MPT_NUM_CAP-1:0] cap_pin,
	input wire logic [`MPT_NUM_CAP*2-1:0] cap_edge,
	input wire logic [`MPT_NUM_CAP-1:0] cap_irq_en,
	// status
	output logic [31:0] count,
	output logic [31:0] prescale_count,
	output logic [`MPT_NUM_CAP*32-1:0] capture_val,
	output logic [`MPT_NUM_MATCH-1:0] match_irq,
	output logic [`MPT_NUM_CAP-1:0] capture_irq,
	output logic [`MPT_NUM_MATCH-1:0] release_pending,
	output logic sync_enable_out,
	// pins
	output logic [`MPT_NUM_PWM-1:0] pwm_out,
	output logic [`MPT_NUM_EXT-1:0] ext_match
);
	import mpt_pkg::*;
	logic [31:0] cnt_q;
	logic [31:0] pre_q;
	logic [31:0] act_q [0:`MPT_NUM_MATCH-1];
	logic [31:0] shadow_q [0:`MPT_NUM_MATCH-1];
	logic [`MPT_NUM_MATCH-1:0] rel_q;
	logic [`MPT_NUM_MATCH-1:0] hit;
	logic [`MPT_NUM_CAP-1:0] cap_lvl;
	logic [`MPT_NUM_CAP-1:0] cap_hit;
	logic run;
	logic src_tick;
	logic step;
	logic do_reset;
	logic do_stop;
	logic stopped_q;
	logic cycle_start;
	logic [`MPT_NUM_PWM-1:0] pwm_q;
	logic [`MPT_NUM_PWM-1:0] rise_hit;
	logic [`MPT_NUM_EXT-1:0] ext_q;
	logic [`MPT_NUM_MATCH-1:0] mirq_q;
	logic [`MPT_NUM_CAP-1:0] cirq_q;
	logic [`MPT_NUM_CAP*32-1:0] capv_q;

	// ***************************************************
	// input synchronisers
	// ***************************************************
	genvar g;
	generate
		for (g = 0; g < `MPT_NUM_CAP; g = g + 1)
		begin : gen_cap
			mpt_edge_sync u_sync
			(
				.clk(clk),
				.rst_b(rst_b),
				.pin(cap_pin[g]),
				.edge_sel(cap_edge[g*2 +: 2]),
				.level(cap_lvl[g]),
				.hit(cap_hit[g])
			);
		end
	endgenerate

	// ***************************************************
	// prescaler and counter
	// ***************************************************
	// slave follows master enable so both start on the same edge
	assign run = (slave_mode ? sync_enable_in : enable) & ~stopped_q; // see R11
	assign sync_enable_out = enable;
	logic cnt_edge;
	logic cnt_lvl_q;
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			cnt_lvl_q <= 1'h0;
		else
			cnt_lvl_q <= cap_lvl[count_cap_sel];
	end
	always_comb
	begin
		cnt_edge = (count_edge[0] & cap_lvl[count_cap_sel] & ~cnt_lvl_q)
			| (count_edge[1] & ~cap_lvl[count_cap_sel] & cnt_lvl_q);
	end
	assign src_tick = counter_mode ? cnt_edge : 1'h1; // see R2
	assign step = run & src_tick & (pre_q == prescale); // see R1
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			pre_q <= `MPT_CNT_RESET;
		else if (run & src_tick)
			pre_q <= (pre_q == prescale) ? 32'h0 : pre_q + 32'h1; // see R1
	end

	// match detect: equality with the active value
	always_comb
	begin
		for (int i = 0; i < `MPT_NUM_MATCH; i++)
			hit[i] = (cnt_q == act_q[i]); // see R14, R15
	end
	always_comb
	begin
		do_reset = 1'h0;
		do_stop = 1'h0;
		for (int i = 0; i < `MPT_NUM_MATCH; i++)
		begin
			do_reset = do_reset | (hit[i] & match_act[i*3+`MPT_ACT_RESET_BIT]);
			do_stop = do_stop | (hit[i] & match_act[i*3+`MPT_ACT_STOP_BIT]);
		end
		// period match always resets in pulse mode
		do_reset = do_reset | (pwm_enable & hit[0]); // see R5
	end
	assign cycle_start = step & do_reset;
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			cnt_q <= `MPT_CNT_RESET;
		else if (step)
			cnt_q <= do_reset ? 32'h0 : cnt_q + 32'h1; // see R15
	end
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			stopped_q <= 1'h0;
		else if (!(slave_mode ? sync_enable_in : enable))
			stopped_q <= 1'h0;
		else if (step & do_stop)
			stopped_q <= 1'h1; // see R4
	end

	// ***************************************************
	// match shadow and release
	// ***************************************************
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			for (int i = 0; i < `MPT_NUM_MATCH; i++)
			begin
				act_q[i] <= 32'hFFFF_FFFF;
				shadow_q[i] <= 32'hFFFF_FFFF;
			end
			rel_q <= '0;
		end
		else
		begin
			for (int i = 0; i < `MPT_NUM_MATCH; i++)
			begin
				if (match_release[i])
				begin
					shadow_q[i] <= match_val[i*32 +: 32];
					rel_q[i] <= 1'h1; // see R9
				end
				// timer mode takes values at once; pulse mode at cycle start
				if ((rel_q[i] & (!pwm_enable | cycle_start)) & !match_release[i])
				begin
					act_q[i] <= shadow_q[i]; // see R9
					rel_q[i] <= 1'h0;
				end
			end
		end
	end
	assign release_pending = rel_q;

	// ***************************************************
	// pulse outputs
	// ***************************************************
	// rise_hit[n] is match n-1; bit 0 has no rising match
	assign rise_hit = {hit[`MPT_NUM_PWM-2:0], 1'h0};
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			pwm_q <= '0;
		else if (!pwm_enable)
			pwm_q <= '0; // see R10
		else if (step)
		begin
			for (int n = 0; n < `MPT_NUM_PWM; n++)
			begin
				if (double_edge[n] && n > 0)
				begin
					// rise on match n-1, fall on match n
					if (hit[n])
						pwm_q[n] <= 1'h0; // see R8
					else if (rise_hit[n])
						pwm_q[n] <= 1'h1; // see R8
				end
				else if (hit[n+1]) // see R7
					pwm_q[n] <= 1'h0; // see R6
				else if (do_reset)
					pwm_q[n] <= ~const_low[n]; // see R6
			end
		end
	end
	assign pwm_out = pwm_q; // see R3

	// ***************************************************
	// external match outputs and flags
	// ***************************************************
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			ext_q <= '0;
		else if (step)
		begin
			for (int e = 0; e < `MPT_NUM_EXT; e++)
				if (hit[e])
					case (mpt_ext_type'(ext_act[e*2 +: 2])) // see R12
						MPT_EXT_LOW: ext_q[e] <= 1'h0;
						MPT_EXT_HIGH: ext_q[e] <= 1'h1;
						MPT_EXT_TOGGLE: ext_q[e] <= ~ext_q[e];
						default: ext_q[e] <= ext_q[e];
					endcase
		end
	end
	assign ext_match = ext_q;
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			mirq_q <= '0;
			cirq_q <= '0;
			capv_q <= '0;
		end
		else
		begin
			for (int i = 0; i < `MPT_NUM_MATCH; i++)
				mirq_q[i] <= step & hit[i]
					& match_act[i*3+`MPT_ACT_IRQ_BIT]; // see R4
			for (int c = 0; c < `MPT_NUM_CAP; c++)
			begin
				cirq_q[c] <= cap_hit[c] & cap_irq_en[c]; // see R13
				if (cap_hit[c])
					capv_q[c*32 +: 32] <= cnt_q; // see R13
			end
		end
	end
	assign match_irq = mirq_q;
	assign capture_irq = cirq_q;
	assign capture_val = capv_q;
	assign count = cnt_q;
	assign prescale_count = pre_q;

	// ***************************************************
	// checks
	// ***************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	a_count_wraps: assert property (step && do_reset |=> cnt_q == 32'h0) // see R15
		else $error("counter did not return to zero");
	a_count_steps: assert property (step && !do_reset |=>
		cnt_q == $past(cnt_q) + 32'h1) // see R1
		else $error("counter did not advance");
	a_count_holds: assert property (!step |=> $stable(cnt_q)) // see R1
		else $error("counter moved without a step");
	a_pwm_off: assert property (!pwm_enable |=> pwm_q == '0) // see R10
		else $error("pulse output active with pulse mode off");
	a_pwm_rise: assert property (pwm_enable && cycle_start && !double_edge[0]
		&& !const_low[0] && !hit[1] |=> pwm_q[0]) // see R6
		else $error("single edge output did not rise");
	a_stop_sticks: assert property (enable && step && do_stop |=>
		!run [*2]) // see R4
		else $error("stop on match did not stop");
	a_capture_take: assert property (cap_hit[0] |=>
		capv_q[31:0] == $past(cnt_q)) // see R13
		else $error("capture did not latch count");
	a_release_apply: assert property (pwm_enable && rel_q[1] && !cycle_start
		&& !match_release[1] |=> $stable(act_q[1])) // see R9
		else $error("match value applied mid cycle");
	c_cycle: cover property (cycle_start ##[1:20] cycle_start);
	c_double: cover property (pwm_enable && double_edge[1] && pwm_q[1]);
	c_capture: cover property (cirq_q[0]);
endmodule

// ### bench/mpt_load.sv
// Purpose: load on one pulse pin, measures period and high time
// Assumes: pin changes only on clk edges
// Notes: figures refer to the last complete period
`timescale 1ns/1ps
module mpt_load
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// pin and figures
	input wire logic pin,
	output logic [31:0] high_len,
	output logic [31:0] period_len
);
	logic prev_q;
	logic [31:0] run_q;
	logic [31:0] hi_q;
	// a period runs from one rising edge to the next
	always_ff @(posedge clk)
	begin
		prev_q <= pin;
		if (!rst_b)
		begin
			run_q <= 32'h0;
			hi_q <= 32'h0;
			high_len <= 32'h0;
			period_len <= 32'h0;
		end
		else if (pin && !prev_q)
		begin
			period_len <= run_q;
			high_len <= hi_q;
			run_q <= 32'h1;
			hi_q <= 32'h1;
		end
		else
		begin
			run_q <= run_q + 32'h1;
			hi_q <= hi_q + {31'h0, pin};
		end
	end
endmodule

// ### bench/tb.sv
// Purpose: self checking bench for the pulse timer
// Assumes: prescale 0 steps the counter every clock
// Notes: period of match value P lasts P+1 counts
`timescale 1ns/1ps
`include "mpt_consts.svh"
module tb;
	import mpt_pkg::*;
	logic clk = 0, rst_b = 0, enable = 0, pwm_enable = 0;
	logic counter_mode = 0, slave_mode = 0, sync_enable_in = 0;
	logic [1:0] count_cap_sel = 2'h0, count_edge = 2'h0;
	logic [5:0] double_edge = 6'h00, const_low = 6'h00;
	logic [31:0] prescale = 32'h0, c, h0, p0, h2, p2, he, pe;
	logic [`MPT_NUM_MATCH*32-1:0] match_val = '0;
	logic [`MPT_NUM_MATCH*3-1:0] match_act = '0;
	logic [`MPT_NUM_MATCH-1:0] match_release = '0, match_irq, release_pending;
	logic [7:0] ext_act = 8'h00, cap_edge = 8'h00;
	logic [3:0] cap_pin = 4'h0, cap_irq_en = 4'h0, capture_irq, ext_match;
	logic [31:0] count, prescale_count;
	logic [127:0] capture_val;
	logic sync_enable_out;
	logic [5:0] pwm_out;
	int bad_count = 0, n_checks = 0, n;
	always #5 clk = ~clk;
	mpt_timer dut (.clk(clk), .rst_b(rst_b), .enable(enable),
		.counter_mode(counter_mode), .count_cap_sel(count_cap_sel),
		.count_edge(count_edge), .pwm_enable(pwm_enable),
		.double_edge(double_edge), .const_low(const_low),
		.slave_mode(slave_mode), .sync_enable_in(sync_enable_in),
		.prescale(prescale), .match_val(match_val), .match_act(match_act),
		.match_release(match_release), .ext_act(ext_act), .cap_pin(cap_pin),
		.cap_edge(cap_edge), .cap_irq_en(cap_irq_en), .count(count),
		.prescale_count(prescale_count), .capture_val(capture_val),
		.match_irq(match_irq), .capture_irq(capture_irq),
		.release_pending(release_pending),
		.sync_enable_out(sync_enable_out), .pwm_out(pwm_out),
		.ext_match(ext_match));
	mpt_load ld0 (.clk(clk), .rst_b(rst_b), .pin(pwm_out[0]),
		.high_len(h0), .period_len(p0));
	mpt_load ld2 (.clk(clk), .rst_b(rst_b), .pin(pwm_out[2]),
		.high_len(h2), .period_len(p2));
	mpt_load lde (.clk(clk), .rst_b(rst_b), .pin(ext_match[0]),
		.high_len(he), .period_len(pe));
	// ************************************************
	// tasks
	// ************************************************
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task cyc(input int k);
		repeat (k) @(negedge clk);
	endtask
	task do_reset;
		@(negedge clk);
		rst_b = 0;
		enable = 0;
		pwm_enable = 0;
		counter_mode = 0;
		slave_mode = 0;
		sync_enable_in = 0;
		match_act = '0;
		ext_act = 8'h00;
		double_edge = 6'h00;
		const_low = 6'h00;
		cap_pin = 4'h0;
		cyc(6);
		rst_b = 1;
	endtask
	// release holds for one cycle, then one idle cycle follows
	task set_match(input int i, input logic [31:0] v, input logic [2:0] a);
		match_val[i*32+:32] = v;
		match_act[i*3+:3] = a;
		match_release[i] = 1;
		@(negedge clk);
		match_release[i] = 0;
		@(negedge clk);
	endtask
	task stop_test;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial
	begin
		#200000;
		bad_count++;
		stop_test();
	end
	// ************************************************
	// tests
	// ************************************************
	initial
	begin
		do_reset();
		prescale = 32'h2;
		enable = 1;
		cyc(2);
		chk(32'(sync_enable_out), 32'h1);
		chk(prescale_count, 32'h2);
		c = count;
		for (n = 0; n < 10 && count === c; n++) @(negedge clk);
		c = count;
		for (n = 0; n < 10 && count === c; n++) @(negedge clk);
		chk(n, 32'h3);
		$display("test prescale done");
		do_reset();
		prescale = 32'h0;
		ext_act = 8'h80;
		cap_edge = 8'h01;
		cap_irq_en = 4'h1;
		set_match(3, 32'h6, 3'h5);
		enable = 1;
		for (n = 0; n < 20 && match_irq[3] !== 1'b1; n++) @(negedge clk);
		cyc(3);
		chk(32'(match_irq[3]), 32'h0);
		chk(count, 32'h7);
		chk(32'(ext_match[3]), 32'h1);
		cap_pin = 4'h1;
		for (n = 0; n < 10 && capture_irq[0] !== 1'b1; n++) @(negedge clk);
		chk(32'(capture_irq[0]), 32'h1);
		chk(capture_val[31:0], 32'h7);
		$display("test stop and capture done");
		do_reset();
		ext_act = 8'h03;
		set_match(0, 32'h5, 3'h2);
		set_match(1, 32'h2, 3'h0);
		pwm_enable = 1;
		enable = 1;
		cyc(40);
		chk(p0, 32'h6);
		chk(h0, 32'h3);
		chk(pe, 32'hC);
		match_val[63:32] = 32'h4;
		cyc(20);
		chk(h0, 32'h3);
		for (n = 0; n < 10 && count !== 32'h1; n++) @(negedge clk);
		set_match(1, 32'h4, 3'h0);
		chk(32'(release_pending[1]), 32'h1);
		cyc(30);
		chk(h0, 32'h5);
		double_edge[2] = 1;
		const_low[0] = 1;
		set_match(1, 32'h1, 3'h0);
		set_match(2, 32'h4, 3'h0);
		cyc(30);
		chk(p2, 32'h6);
		chk(h2, 32'h3);
		chk(32'(pwm_out[0]), 32'h0);
		set_match(1, 32'h4, 3'h0);
		set_match(2, 32'h2, 3'h0);
		cyc(30);
		chk(h2, 32'h4);
		$display("test pulse outputs done");
		do_reset();
		set_match(0, 32'h5, 3'h2);
		set_match(1, 32'h2, 3'h0);
		enable = 1;
		for (n = 0; n < 6; n++)
		begin
			cyc(3);
			chk(32'(pwm_out), 32'h0);
			chk(32'(count <= 32'h5), 32'h1);
		end
		$display("test plain timer done");
		do_reset();
		counter_mode = 1;
		count_cap_sel = 2'h1;
		count_edge = 2'h1;
		enable = 1;
		cyc(4);
		chk(count, 32'h0);
		repeat (3)
		begin
			cap_pin[1] = 1;
			cyc(3);
			cap_pin[1] = 0;
			cyc(3);
		end
		chk(count, 32'h3);
		$display("test counter mode done");
		do_reset();
		slave_mode = 1;
		sync_enable_in = 1;
		cyc(5);
		chk(count, 32'h5);
		sync_enable_in = 0;
		cyc(3);
		chk(count, 32'h5);
		$display("test slave follow done");
		stop_test();
	end
endmodule
